// ===== jdap_pkg.sv
package jdap_pkg;

  localparam int IR_W   = 4;
  localparam int DR_W   = 42;
  localparam int ID_W   = 32;
  localparam int TAP_N  = 2;
  localparam int ADDR_W = 8;

  // instruction codes shared by both taps; access exists on the chip tap only
  localparam logic [IR_W-1:0] IR_BYPASS   = 4'hf;
  localparam logic [IR_W-1:0] IR_DEVICE_IDENTIFICATION   = 4'h1;
  localparam logic [IR_W-1:0] IR_USERCODE = 4'h2;
  localparam logic [IR_W-1:0] IR_ACCESS   = 4'h3;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;

  // security register bit positions
  localparam int SEC_NO_TEST_PORT = 0;
  localparam int SEC_NO_TEST_OTP  = 13;
  localparam int SEC_NO_DEBUG     = 14;
  localparam int SEC_UID_LO       = 22;
  localparam int SEC_UID_HI       = 31;

  // user code fields
  localparam int UC_UID_LO = 22;
  localparam int UC_REV_W  = 16;

  // access register layout, lsb first: wdata, addr, otp, wr
  localparam int ACC_ADDR_LO = 32;
  localparam int ACC_OTP     = 40;
  localparam int ACC_WR      = 41;

  localparam logic [DR_W-1:0] DR_RST = 42'h000_0000_0000;
  // pin synchroniser reset: the debug pin idles high, so no false edge after reset
  localparam logic [7:0]      SYNC_RST = 8'h10;

  typedef enum logic [3:0] {
    TS_RESET   = 4'h0, TS_IDLE    = 4'h1, TS_SEL_DR  = 4'h3, TS_CAP_DR  = 4'h2,
    TS_SHF_DR  = 4'h6, TS_EX1_DR  = 4'h7, TS_PAU_DR  = 4'h5, TS_EX2_DR  = 4'h4,
    TS_UPD_DR  = 4'hc, TS_SEL_IR  = 4'hd, TS_CAP_IR  = 4'hf, TS_SHF_IR  = 4'he,
    TS_EX1_IR  = 4'ha, TS_PAU_IR  = 4'hb, TS_EX2_IR  = 4'h9, TS_UPD_IR  = 4'h8
  } jdap_tap_e;

  typedef enum logic [1:0] {
    BS_WAIT = 2'b00, BS_GO = 2'b01, BS_RUN = 2'b11
  } jdap_boot_e;

  typedef struct packed {
    logic              wr;
    logic              otp;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } jdap_acc_s;

endpackage : jdap_pkg

// ===== jdap_top.sv
`timescale 1ns/10ps
module jdap_top #(
  parameter logic [3:0]  ID_VERSION = 4'h0,
  parameter logic [15:0] ID_PART    = 16'h0a5c,   // arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h155,    // arbitrary value
  parameter logic [15:0] REVISION   = 16'h2800
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  // test port pins
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  input  wire logic                    trst_n,
  output logic                         tdo,
  output logic                         tdo_oe,
  // debug sync pin
  input  wire logic                    debug_i,
  output logic                         debug_o,
  output logic                         debug_oe,
  // tile side
  input  wire logic [31:0]             sec_reg,
  input  wire logic                    dbg_out_mode,
  input  wire logic                    dbg_in_en,
  input  wire logic                    break_hit,
  input  wire logic                    break_clr,
  output logic                         debug_req,
  output jdap_pkg::jdap_acc_s          acc_req,
  output logic                         acc_valid,
  output logic                         acc_refused,
  input  wire logic [31:0]             acc_rdata,
  // boot
  input  wire logic                    pll_lock,
  input  wire logic [1:0]              boot_mode,
  output logic                         boot_start,
  output logic [1:0]                   boot_mode_q
);
  localparam int NS = 8;
  logic [NS-1:0] s1_r, s2_r;
  logic          tck_d_r, dbg_d_r;
  logic          tck_s, tms_s, tdi_s, trst_s, dbg_s, pll_s;
  logic [1:0]    bm_s;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r    <= jdap_pkg::SYNC_RST;
      s2_r    <= jdap_pkg::SYNC_RST;
      tck_d_r <= 1'b0;
      dbg_d_r <= 1'b1;
    end else if (clk_en) begin
      s1_r    <= {boot_mode, pll_lock, debug_i, trst_n, tdi, tms, tck};
      s2_r    <= s1_r;
      tck_d_r <= tck_s;
      dbg_d_r <= dbg_s;
    end
  end
  assign {bm_s, pll_s, dbg_s, trst_s, tdi_s, tms_s, tck_s} = s2_r;
  wire tck_rise = clk_en && tck_s && !tck_d_r;
  wire tck_fall = clk_en && !tck_s && tck_d_r;
  function automatic jdap_pkg::jdap_tap_e tap_next(jdap_pkg::jdap_tap_e s, logic m);
    case (s)
      jdap_pkg::TS_RESET:  tap_next = m ? jdap_pkg::TS_RESET  : jdap_pkg::TS_IDLE;
      jdap_pkg::TS_IDLE:   tap_next = m ? jdap_pkg::TS_SEL_DR : jdap_pkg::TS_IDLE;
      jdap_pkg::TS_SEL_DR: tap_next = m ? jdap_pkg::TS_SEL_IR : jdap_pkg::TS_CAP_DR;
      jdap_pkg::TS_CAP_DR: tap_next = m ? jdap_pkg::TS_EX1_DR : jdap_pkg::TS_SHF_DR;
      jdap_pkg::TS_SHF_DR: tap_next = m ? jdap_pkg::TS_EX1_DR : jdap_pkg::TS_SHF_DR;
      jdap_pkg::TS_EX1_DR: tap_next = m ? jdap_pkg::TS_UPD_DR : jdap_pkg::TS_PAU_DR;
      jdap_pkg::TS_PAU_DR: tap_next = m ? jdap_pkg::TS_EX2_DR : jdap_pkg::TS_PAU_DR;
      jdap_pkg::TS_EX2_DR: tap_next = m ? jdap_pkg::TS_UPD_DR : jdap_pkg::TS_SHF_DR;
      jdap_pkg::TS_UPD_DR: tap_next = m ? jdap_pkg::TS_SEL_DR : jdap_pkg::TS_IDLE;
      jdap_pkg::TS_SEL_IR: tap_next = m ? jdap_pkg::TS_RESET  : jdap_pkg::TS_CAP_IR;
      jdap_pkg::TS_CAP_IR: tap_next = m ? jdap_pkg::TS_EX1_IR : jdap_pkg::TS_SHF_IR;
      jdap_pkg::TS_SHF_IR: tap_next = m ? jdap_pkg::TS_EX1_IR : jdap_pkg::TS_SHF_IR;
      jdap_pkg::TS_EX1_IR: tap_next = m ? jdap_pkg::TS_UPD_IR : jdap_pkg::TS_PAU_IR;
      jdap_pkg::TS_PAU_IR: tap_next = m ? jdap_pkg::TS_EX2_IR : jdap_pkg::TS_PAU_IR;
      jdap_pkg::TS_EX2_IR: tap_next = m ? jdap_pkg::TS_UPD_IR : jdap_pkg::TS_SHF_IR;
      jdap_pkg::TS_UPD_IR: tap_next = m ? jdap_pkg::TS_SEL_DR : jdap_pkg::TS_IDLE;
      default:             tap_next = jdap_pkg::TS_RESET;
    endcase
  endfunction : tap_next
  jdap_pkg::jdap_tap_e st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (!trst_s) st_nxt = jdap_pkg::TS_RESET;
    else if (tck_rise) st_nxt = tap_next(st_r, tms_s);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) st_r <= jdap_pkg::TS_RESET;
    else if (clk_en) st_r <= st_nxt;
  end
  wire [31:0] device_identification   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  wire [31:0] usercode = {sec_reg[jdap_pkg::SEC_UID_HI:jdap_pkg::SEC_UID_LO],
                          {(jdap_pkg::UC_UID_LO - jdap_pkg::UC_REV_W){1'b0}}, REVISION};
  wire        no_port  = sec_reg[jdap_pkg::SEC_NO_TEST_PORT];
  logic [jdap_pkg::IR_W-1:0] ir_r [jdap_pkg::TAP_N];   // 0 boundary scan, 1 chip access
  logic [jdap_pkg::DR_W-1:0] dr_r [jdap_pkg::TAP_N];
  logic [jdap_pkg::TAP_N:0]  chain;
  assign chain[0] = tdi_s;
    for (genvar t = 0; t < jdap_pkg::TAP_N; t++) begin : g_tap
      logic [jdap_pkg::IR_W-1:0] irs_r, irs_nxt, ir_nxt;
      logic [jdap_pkg::DR_W-1:0] dr_nxt;
      logic                      acc_sel;
      int                        len;
      assign acc_sel  = (t == 1) && (ir_r[t] == jdap_pkg::IR_ACCESS);
      assign chain[t+1] = (st_r == jdap_pkg::TS_SHF_IR) ? irs_r[0] : dr_r[t][0];
      always_comb begin
        irs_nxt = irs_r;
        ir_nxt  = ir_r[t];
        dr_nxt  = dr_r[t];
        len     = 1;
        if (ir_r[t] == jdap_pkg::IR_DEVICE_IDENTIFICATION || ir_r[t] == jdap_pkg::IR_USERCODE) len = 32;
        if (acc_sel) len = jdap_pkg::DR_W;
        if (st_r == jdap_pkg::TS_RESET) begin
          ir_nxt = jdap_pkg::IR_DEVICE_IDENTIFICATION;
        end else if (tck_rise) begin
          case (st_r)
            jdap_pkg::TS_CAP_IR: irs_nxt = jdap_pkg::IR_CAPTURE;
            jdap_pkg::TS_SHF_IR: irs_nxt = {chain[t], irs_r[jdap_pkg::IR_W-1:1]};
            jdap_pkg::TS_UPD_IR: ir_nxt = irs_r;
            jdap_pkg::TS_CAP_DR: begin
              dr_nxt = jdap_pkg::DR_RST;
              if (ir_r[t] == jdap_pkg::IR_DEVICE_IDENTIFICATION) dr_nxt[31:0] = device_identification;
              else if (ir_r[t] == jdap_pkg::IR_USERCODE) dr_nxt[31:0] = usercode;
              else if (acc_sel && !no_port) dr_nxt[31:0] = acc_rdata;
            end
            jdap_pkg::TS_SHF_DR: begin
              dr_nxt = dr_r[t] >> 1;
              dr_nxt[len-1] = chain[t];
            end
            default: ;
          endcase
        end
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          irs_r   <= jdap_pkg::IR_CAPTURE;
          ir_r[t] <= jdap_pkg::IR_DEVICE_IDENTIFICATION;
          dr_r[t] <= jdap_pkg::DR_RST;
        end else if (clk_en) begin
          irs_r   <= irs_nxt;
          ir_r[t] <= ir_nxt;
          dr_r[t] <= dr_nxt;
        end
      end
    end

  // tdo on the falling test clock, tile access on update
  logic tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
  logic acc_valid_r, acc_valid_nxt, acc_ref_r, acc_ref_nxt;
  jdap_pkg::jdap_acc_s acc_r, acc_nxt;
  wire shifting = (st_r == jdap_pkg::TS_SHF_IR) || (st_r == jdap_pkg::TS_SHF_DR);
  wire do_upd   = tck_rise && st_r == jdap_pkg::TS_UPD_DR && trst_s
                  && ir_r[1] == jdap_pkg::IR_ACCESS;
  wire req_otp  = dr_r[1][jdap_pkg::ACC_OTP];
  wire blocked  = no_port || (req_otp && sec_reg[jdap_pkg::SEC_NO_TEST_OTP]);
  always_comb begin
    tdo_nxt       = tdo_r;
    tdo_oe_nxt    = tdo_oe_r;
    acc_nxt       = acc_r;
    acc_valid_nxt = 1'b0;
    acc_ref_nxt   = 1'b0;
    if (tck_fall) begin
      tdo_nxt    = chain[jdap_pkg::TAP_N];
      tdo_oe_nxt = shifting;
    end
    if (do_upd) begin
      // a refused request still loads acc_req but never raises acc_valid, so no otp write is issued
      acc_nxt       = jdap_pkg::jdap_acc_s'(dr_r[1]);
      acc_valid_nxt = !blocked;
      acc_ref_nxt   = blocked;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tdo_r       <= 1'b0;
      tdo_oe_r    <= 1'b0;
      acc_r       <= '0;
      acc_valid_r <= 1'b0;
      acc_ref_r   <= 1'b0;
    end else if (clk_en) begin
      tdo_r       <= tdo_nxt;
      tdo_oe_r    <= tdo_oe_nxt;
      acc_r       <= acc_nxt;
      acc_valid_r <= acc_valid_nxt;
      acc_ref_r   <= acc_ref_nxt;
    end
  end

  logic brk_r, brk_nxt, dbg_oe_r, dbg_oe_nxt, dbg_req_r, dbg_req_nxt;
  wire  dbg_off = sec_reg[jdap_pkg::SEC_NO_DEBUG];
  always_comb begin
    brk_nxt     = brk_r;
    if (break_clr) brk_nxt = 1'b0;
    if (break_hit) brk_nxt = 1'b1;                                  // set beats clear
    dbg_oe_nxt  = dbg_out_mode && brk_nxt && !dbg_off;
    dbg_req_nxt = !dbg_out_mode && dbg_in_en && !dbg_off
                  && !dbg_s && dbg_d_r;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      brk_r     <= 1'b0;
      dbg_oe_r  <= 1'b0;
      dbg_req_r <= 1'b0;
    end else if (clk_en) begin
      brk_r     <= brk_nxt;
      dbg_oe_r  <= dbg_oe_nxt;
      dbg_req_r <= dbg_req_nxt;
    end
  end

  jdap_pkg::jdap_boot_e bst_r, bst_nxt;
  logic [1:0] bm_r, bm_nxt;
  logic       go_r, go_nxt;
  always_comb begin
    bst_nxt = bst_r;
    bm_nxt  = bm_r;
    case (bst_r)
      jdap_pkg::BS_WAIT: if (pll_s) begin
        bst_nxt = jdap_pkg::BS_GO;
        bm_nxt  = bm_s;
      end
      jdap_pkg::BS_GO:   bst_nxt = jdap_pkg::BS_RUN;
      jdap_pkg::BS_RUN:  bst_nxt = jdap_pkg::BS_RUN;
      default:           bst_nxt = jdap_pkg::BS_WAIT;
    endcase
    go_nxt = (bst_nxt == jdap_pkg::BS_GO);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bst_r <= jdap_pkg::BS_WAIT;
      bm_r  <= 2'h0;
      go_r  <= 1'b0;
    end else if (clk_en) begin
      bst_r <= bst_nxt;
      bm_r  <= bm_nxt;
      go_r  <= go_nxt;
    end
  end
  assign tdo         = tdo_r;
  assign tdo_oe      = tdo_oe_r;
  assign debug_o     = 1'b0 & brk_r;
  assign debug_oe    = dbg_oe_r;
  assign debug_req   = dbg_req_r;
  assign acc_req     = acc_r;
  assign acc_valid   = acc_valid_r;
  assign acc_refused = acc_ref_r;
  assign boot_start  = go_r;
  assign boot_mode_q = bm_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_trst; clk_en && !trst_s |=> st_r == jdap_pkg::TS_RESET; endproperty
  a_trst: assert property (p_trst) else $error("tap not held in reset");
  property p_fsm; clk_en && tck_rise && trst_s && st_r == jdap_pkg::TS_RESET && !tms_s
    |=> st_r == jdap_pkg::TS_IDLE; endproperty
  a_fsm: assert property (p_fsm) else $error("reset state did not step to idle");
  property p_idc; st_r == jdap_pkg::TS_RESET && clk_en |=> ir_r[0] == jdap_pkg::IR_DEVICE_IDENTIFICATION
    && ir_r[1] == jdap_pkg::IR_DEVICE_IDENTIFICATION; endproperty
  a_idc: assert property (p_idc) else $error("taps not on device_identification after reset");
  property p_idv; clk_en && tck_rise && trst_s && st_r == jdap_pkg::TS_CAP_DR
    && ir_r[0] == jdap_pkg::IR_DEVICE_IDENTIFICATION |=> dr_r[0][0] && dr_r[0][31:0] == device_identification; endproperty
  a_idv: assert property (p_idv) else $error("device_identification capture wrong");
  property p_uc; clk_en && tck_rise && trst_s && st_r == jdap_pkg::TS_CAP_DR
    && ir_r[1] == jdap_pkg::IR_USERCODE
    |=> dr_r[1][31:22] == $past(sec_reg[31:22]) && dr_r[1][15:0] == REVISION; endproperty
  a_uc: assert property (p_uc) else $error("usercode capture wrong");
  property p_blk; acc_valid_r |-> !$past(no_port); endproperty
  a_blk: assert property (p_blk) else $error("access while port disabled");
  property p_otp; acc_valid_r |-> !(acc_r.otp && $past(sec_reg[13])); endproperty
  a_otp: assert property (p_otp) else $error("otp access while locked");
  property p_dbo; dbg_oe_r |-> brk_r && $past(dbg_out_mode); endproperty
  a_dbo: assert property (p_dbo) else $error("debug pin driven without break");
  property p_dbi; clk_en && dbg_off |=> !dbg_req_r && !dbg_oe_r; endproperty
  a_dbi: assert property (p_dbi) else $error("debug pin not ignored");
  property p_boot; $rose(boot_start) |-> $past(pll_s); endproperty
  a_boot: assert property (p_boot) else $error("boot before pll lock");
  c_acc:  cover property (acc_valid_r);
  c_ref:  cover property (acc_ref_r);
  c_dreq: cover property (dbg_req_r);
  c_boot: cover property (boot_start);
endmodule : jdap_top

// ===== jdap_host.sv
`timescale 1ns/10ps
module jdap_host #(
  parameter int HALF = 6
) (
  // pacing clock
  input  wire logic core_clk,
  // test port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
  end

  // tck idles low outside frames; the half period covers the pin synchronisers
  task automatic pulse(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (HALF) @(negedge core_clk);
    // an undriven line reads as the wrong bit, so a missing enable is caught
    q = tdo_oe ? tdo : ~tdo;
    tck = 1'b1;
    repeat (HALF) @(negedge core_clk);
    tck = 1'b0;
  endtask : pulse

  // from idle to shift, n bits lsb first, back to idle; tdi toggles when unused
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = '0;
    pulse(1'b1, ~tdi, q);
    if (ir) begin
      pulse(1'b1, ~tdi, q);
    end
    pulse(1'b0, ~tdi, q);
    pulse(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, ~tdi, q);
    pulse(1'b0, ~tdi, q);
  endtask : scan

  task automatic tap_reset();
    logic q;
    trst_n = 1'b0;
    repeat (8) @(negedge core_clk);
    trst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    pulse(1'b0, ~tdi, q);
  endtask : tap_reset
endmodule : jdap_host

// ===== tb_jtag_debug_access_port.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_jtag_debug_access_port;
  // id fields are arbitrary values
  localparam logic [31:0] IDV = {4'h0, 16'h0a5c, 11'h155, 1'b1};
  localparam logic [15:0] REV = 16'h2800;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, debug_o, debug_oe, debug_req;
  logic dbg_out_mode, dbg_in_en, break_hit, break_clr, ext_low, debug_pin;
  logic acc_valid, acc_refused, pll_lock, boot_start, blk;
  logic [31:0] sec_reg, acc_rdata;
  logic [1:0] boot_mode, boot_mode_q;
  logic [63:0] din, dout;
  jdap_pkg::jdap_acc_s acc_req;
  int err_total, checks_done, n_val, n_ref, n_req, n_boot, seed, b0, b1;

  always #20 core_clk = ~core_clk;
  // open-drain pin with pull-up
  assign debug_pin = (debug_oe === 1'b1 || ext_low) ? 1'b0 : 1'b1;

  always @(posedge core_clk) begin
    n_val += int'(acc_valid === 1'b1);
    n_ref += int'(acc_refused === 1'b1);
    n_req += int'(debug_req === 1'b1);
    n_boot += int'(boot_start === 1'b1);
  end

  jdap_host host (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));

  jdap_top #(.ID_VERSION(IDV[31:28]), .ID_PART(IDV[27:12]), .ID_MAKER(IDV[11:1]),
    .REVISION(REV)) dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .debug_i(debug_pin), .debug_o(debug_o), .debug_oe(debug_oe), .sec_reg(sec_reg),
    .dbg_out_mode(dbg_out_mode), .dbg_in_en(dbg_in_en), .break_hit(break_hit),
    .break_clr(break_clr), .debug_req(debug_req), .acc_req(acc_req),
    .acc_valid(acc_valid), .acc_refused(acc_refused), .acc_rdata(acc_rdata),
    .pll_lock(pll_lock), .boot_mode(boot_mode), .boot_start(boot_start),
    .boot_mode_q(boot_mode_q));

  function automatic logic [31:0] uc_exp(input logic [31:0] s);
    return {s[31:22], 6'h0, REV};
  endfunction : uc_exp

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    seed = 32'h5e5d;
    sec_reg = '0;
    acc_rdata = '0;
    {dbg_out_mode, dbg_in_en, break_hit, break_clr, pll_lock, ext_low} = '0;
    boot_mode = '0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (10) @(negedge core_clk);
    `CHK(n_boot, 0)
    boot_mode = 2'($random(seed));
    pll_lock = 1'b1;
    for (int k = 0; k < 20; k++) begin
      if (n_boot == 0) @(negedge core_clk);
    end
    repeat (8) @(negedge core_clk);
    `CHK(n_boot, 1)
    `CHK(boot_mode_q, boot_mode)
    if (n_boot == 0) end_of_test();
    $display("test boot done");
    host.tap_reset();
    host.scan(1'b0, 64, '0, dout);
    `CHK(dout, {IDV, IDV})
    `CHK(tdo_oe, 1'b0)
    for (int i = 0; i < 2; i++) begin
      sec_reg = (i == 1) ? $random(seed) : 32'h0;
      host.scan(1'b1, 8, 64'hf2, dout);
      `CHK(dout[7:0], 8'h11)
      host.scan(1'b0, 33, '0, dout);
      `CHK(dout[32:0], {1'b0, uc_exp(sec_reg)})
    end
    host.tap_reset();
    host.scan(1'b0, 64, '0, dout);
    `CHK(dout, {IDV, IDV})
    $display("test id done");
    host.scan(1'b1, 8, 64'hf3, dout);
    for (int i = 0; i < 4; i++) begin
      sec_reg = $random(seed) & 32'hffff_9ffe;
      sec_reg[0] = (i == 1);
      sec_reg[13] = (i >= 2);
      acc_rdata = $random(seed);
      din = {$random(seed), $random(seed)};
      din[40] = (i == 2);
      blk = (i == 1 || i == 2);
      b0 = n_val;
      b1 = n_ref;
      host.scan(1'b0, 43, din, dout);
      `CHK(n_ref - b1, int'(blk))
      `CHK(n_val - b0, int'(!blk))
      `CHK(dout[31:0], (i == 1) ? 32'h0 : acc_rdata)
      if (!blk) `CHK(acc_req, din[41:0])
    end
    $display("test access done");
    dbg_out_mode = 1'b1;
    for (int j = 0; j < 2; j++) begin
      sec_reg[14] = (j == 1);
      repeat (4) @(negedge core_clk);
      `CHK(debug_oe, 1'b0)
      break_hit = 1'b1;
      @(negedge core_clk);
      break_hit = 1'b0;
      repeat (3) @(negedge core_clk);
      `CHK(debug_oe, (j == 0))
      `CHK(debug_o, 1'b0)
      break_clr = 1'b1;
      @(negedge core_clk);
      break_clr = 1'b0;
    end
    dbg_out_mode = 1'b0;
    // each pass gives the synchroniser a clean high-to-low edge
    for (int j = 0; j < 3; j++) begin
      dbg_in_en = (j != 1);
      sec_reg[14] = (j == 2);
      b0 = n_req;
      ext_low = 1'b1;
      repeat (8) @(negedge core_clk);
      ext_low = 1'b0;
      repeat (8) @(negedge core_clk);
      `CHK(n_req - b0, int'(j == 0))
    end
    $display("test debug pin done");
    end_of_test();
  end
endmodule : tb_jtag_debug_access_port
